// [include/tcof_regs.svh]
// Register offsets, bit positions and timing counts for the T1 counter
// overflow event flags. Included by the package and design files.
`ifndef TCOF_REGS_SVH
`define TCOF_REGS_SVH

`define TCOF_OFF_WRAP_IRQ 5'h1d
`define TCOF_OFF_EVENT_IRQ 5'h1e
`define TCOF_OFF_WRAP_LATCH 5'h1f
`define TCOF_RESET_WORD 8'h00

`define TCOF_CNT_ALL_ONES 8'hff
`define TCOF_CNT_ZERO 8'h00

`define TCOF_BIT_LINK_A 6
`define TCOF_BIT_LINK_B 5
`define TCOF_BIT_LOOP 4
`define TCOF_BIT_ONE_SEC 3
`define TCOF_BIT_FIVE_SEC 2
`define TCOF_BIT_MESSAGE 1
`define TCOF_BIT_SIGNALING 0

`define TCOF_SYS_CLK_KHZ 125000
`define TCOF_LOOP_HOLD_MS 48
`define TCOF_LOOP_HOLD_CYC (`TCOF_LOOP_HOLD_MS * `TCOF_SYS_CLK_KHZ)

`define TCOF_BOM_LEN 14
`define TCOF_BOM_HIST 10
`define TCOF_BOM_ACCEPT 8
`define TCOF_BOM_FLAG 8'hfe
`define TCOF_SIG_DEBOUNCE 2

`endif

// [include/tcof_pkg.sv]
// Types shared by the counter overflow event flag logic.
// Assumes tcof_regs.svh is on the include path.
`include "tcof_regs.svh"

package tcof_pkg;

	typedef enum logic {BOM_HUNT, BOM_TRACK} tcof_bom_state_type;

	typedef logic [7:0] tcof_word_type;

endpackage : tcof_pkg

// [logic/tcof_bom_detect.sv]
// Bit-oriented message detector on the facility data link.
// Assumes link_bit is sampled in the sys_clk domain when link_bit_en is high.
`timescale 1ns/1ps
`include "tcof_regs.svh"

module tcof_bom_detect import tcof_pkg::*; (
	input wire logic sys_clk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic link_bit, // received data link bit
	input wire logic link_bit_en, // bit strobe
	output logic msg_new // pulse: new message accepted
);
	tcof_bom_state_type state_r;
	logic [13:0] sh_r;
	logic [13:0] sh_nxt;
	logic [3:0] pos_r;
	logic [5:0] hist_r [`TCOF_BOM_HIST];
	logic [4:0] acc_r;
	logic acc_valid_r;
	logic hit;
	logic slot;
	logic [3:0] votes;

	assign sh_nxt = {sh_r[12:0], link_bit};
	assign hit = (sh_nxt[13:6] == `TCOF_BOM_FLAG) && !sh_nxt[0];
	// A message position is any hit while hunting, or every 14th bit
	assign slot = link_bit_en && ((state_r == BOM_HUNT) ? hit :
		(pos_r == 4'(`TCOF_BOM_LEN - 1)));

	always_comb begin
		votes = 4'h1;
		for (int k = 0; k < `TCOF_BOM_HIST - 1; k++) begin
			if (hist_r[k] == {1'b1, sh_nxt[5:1]})
				votes = votes + 4'h1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sh_r <= 14'h0000;
			state_r <= BOM_HUNT;
			pos_r <= 4'h0;
		end else if (link_bit_en) begin
			sh_r <= sh_nxt;
			pos_r <= slot ? 4'h0 : pos_r + 4'h1;
			case (state_r)
				BOM_HUNT: if (hit) state_r <= BOM_TRACK;
				BOM_TRACK: if (slot && !hit) state_r <= BOM_HUNT;
				default: state_r <= BOM_HUNT;
			endcase
		end
	end

	// Missing messages push an empty slot so they still count as positions
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			for (int k = 0; k < `TCOF_BOM_HIST; k++)
				hist_r[k] <= 6'h00;
		end else if (slot) begin
			hist_r[0] <= {hit, sh_nxt[5:1]};
			for (int k = 1; k < `TCOF_BOM_HIST; k++)
				hist_r[k] <= hist_r[k-1];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acc_r <= 5'h00;
			acc_valid_r <= 1'b0;
			msg_new <= 1'b0;
		end else begin
			msg_new <= 1'b0;
			if (slot && hit && votes >= 4'(`TCOF_BOM_ACCEPT) &&
				(!acc_valid_r || acc_r != sh_nxt[5:1])) begin
				acc_r <= sh_nxt[5:1];
				acc_valid_r <= 1'b1;
				msg_new <= 1'b1;
			end
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_bom_vote: assert property (msg_new |-> $past(votes) >= 4'd8)
		else $error("message accepted with too few votes");
endmodule : tcof_bom_detect

// [logic/tcof_sig_change.sv]
// Signaling change detector with optional debounce.
// Assumes sig_bits is presented in the sys_clk domain with a sample strobe.
`timescale 1ns/1ps
`include "tcof_regs.svh"

module tcof_sig_change import tcof_pkg::*; (
	input wire logic sys_clk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic [3:0] sig_bits, // received AB or ABCD bits
	input wire logic sig_en, // sample strobe
	input wire logic debounce_en, // require stable repeats
	output logic sig_change // pulse: accepted change
);
	logic [3:0] last_r;
	logic [3:0] cand_r;
	logic [1:0] cnt_r;
	logic take;

	// Debounce trades a sample period of latency for glitch rejection
	assign take = sig_en && (sig_bits != last_r) && (!debounce_en ||
		(sig_bits == cand_r && cnt_r == 2'(`TCOF_SIG_DEBOUNCE - 1)));

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			last_r <= 4'h0;
			cand_r <= 4'h0;
			cnt_r <= 2'h0;
			sig_change <= 1'b0;
		end else begin
			sig_change <= take;
			if (take) begin
				last_r <= sig_bits;
				cnt_r <= 2'h0;
			end else if (sig_en) begin
				cand_r <= sig_bits;
				cnt_r <= (sig_bits == cand_r && sig_bits != last_r) ?
					cnt_r + 2'h1 : 2'h1;
			end
		end
	end
endmodule : tcof_sig_change

// [logic/tcof_event_flags.sv]
// T1 counter overflow interrupt words, event word and overflow latch.
// Assumes counters, flags and line bits all come from the sys_clk domain,
// and that the processor port strobes cpu_rd for one cycle per read.
//
// Operation
// - framing error counter wrap sets word-two bit 7
// - CRC-6 counter wrap sets word-two bit 6
// - out-of-frame counter wrap sets bit 5
// - alignment-change counter wrap sets bit 4
// - bipolar violation counter wrap sets bit 3
// - PRBS error counter wrap sets bit 2
// - PRBS multiframe counter wrap sets bit 1
// - multiframe sync-loss counter wrap sets bit 0
// - bits stay set until their word is read
// - masked sources never raise their word-two or word-three bit
// - first data link controller sets word-three bit 6
// - second data link controller sets bit 5
// - loop code held 48 ms sets bit 4
// - one-second flag rising sets bit 3
// - five-second flag rising sets bit 2
// - new bit-oriented message sets bit 1
// - message accepted after 8 of 10 positions
// - overflow latch records every wrap, read clears
`timescale 1ns/1ps
`include "tcof_regs.svh"

module tcof_event_flags import tcof_pkg::*; #(
	parameter int LOOP_HOLD_CYC = `TCOF_LOOP_HOLD_CYC
) (
	input wire logic sys_clk, // 125 MHz framer clock
	input wire logic rst, // synchronous reset
	input wire logic cpu_rd, // one-cycle read strobe
	input wire logic [4:0] cpu_addr, // register offset
	output logic [7:0] cpu_rdata, // read data
	output logic cpu_rdata_valid, // read data valid pulse
	input wire logic [7:0][7:0] perf_cnt, // counters, index = bit
	input wire logic [7:0] wrap_unmask, // 1 lets word-two bit set
	input wire logic [6:0] event_unmask, // 1 lets word-three bit set
	input wire logic data_link_ctrl_a_irq, // controller A pulse
	input wire logic data_link_ctrl_b_irq, // controller B pulse
	input wire logic rx_line_bit, // received line bit
	input wire logic rx_bit_en, // line bit strobe
	input wire logic one_second_flag, // one-second status
	input wire logic five_second_flag, // five-second status
	input wire logic facility_data_link, // data link bit
	input wire logic facility_data_link_en, // data link bit strobe
	input wire logic [3:0] sig_bits, // received signaling bits
	input wire logic sig_en, // signaling sample strobe
	input wire logic signaling_debounce_enable // debounce on
);
	localparam int LOOP_W = $clog2(LOOP_HOLD_CYC + 1);

	function automatic logic is_wrap(input logic [7:0] prev,
		input logic [7:0] cur);
		is_wrap = (prev == `TCOF_CNT_ALL_ONES) && (cur == `TCOF_CNT_ZERO);
	endfunction : is_wrap

	function automatic logic reads(input logic rd, input logic [4:0] a,
		input logic [4:0] off);
		reads = rd && (a == off);
	endfunction : reads

	tcof_word_type wrap_irq_r;
	tcof_word_type event_irq_r;
	tcof_word_type wrap_latch_r;
	logic [7:0][7:0] prev_cnt_r;
	logic [7:0] wrap_evt;
	logic [6:0] event_evt;
	logic rd_wrap;
	logic rd_event;
	logic rd_latch;

	assign rd_wrap = reads(cpu_rd, cpu_addr, `TCOF_OFF_WRAP_IRQ);
	assign rd_event = reads(cpu_rd, cpu_addr, `TCOF_OFF_EVENT_IRQ);
	assign rd_latch = reads(cpu_rd, cpu_addr, `TCOF_OFF_WRAP_LATCH);

	// Counter wrap detection

	always_ff @(posedge sys_clk) begin
		if (rst)
			prev_cnt_r <= '0;
		else
			prev_cnt_r <= perf_cnt;
	end

	// A counter reset to zero from a value other than all ones is no wrap
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_wrap
			assign wrap_evt[gi] = is_wrap(prev_cnt_r[gi], perf_cnt[gi]);
		end
	endgenerate

	// Counter overflow interrupt word

	always_ff @(posedge sys_clk) begin
		if (rst)
			wrap_irq_r <= `TCOF_RESET_WORD;
		else
			wrap_irq_r <= (rd_wrap ? `TCOF_RESET_WORD : wrap_irq_r) |
				(wrap_evt & wrap_unmask);
	end

	// Overflow latch ignores the mask: it is a pure record of wraps

	always_ff @(posedge sys_clk) begin
		if (rst)
			wrap_latch_r <= `TCOF_RESET_WORD;
		else
			wrap_latch_r <= (rd_latch ? `TCOF_RESET_WORD : wrap_latch_r) |
				wrap_evt;
	end

	// Second tick edge detection

	logic one_sec_d_r;
	logic five_sec_d_r;
	logic one_sec_rise;
	logic five_sec_rise;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			one_sec_d_r <= 1'b0;
			five_sec_d_r <= 1'b0;
		end else begin
			one_sec_d_r <= one_second_flag;
			five_sec_d_r <= five_second_flag;
		end
	end

	assign one_sec_rise = one_second_flag && !one_sec_d_r;
	assign five_sec_rise = five_second_flag && !five_sec_d_r;

	// Loop code detection
	// A repeating code matches when the new bit equals the bit one period
	// back and the last period held exactly one mark. All zeros never match.

	logic [4:0] line_hist_r;
	logic up_ok_r;
	logic down_ok_r;
	logic [LOOP_W-1:0] loop_cnt_r;
	logic loop_evt;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			line_hist_r <= 5'h00;
			up_ok_r <= 1'b0;
			down_ok_r <= 1'b0;
		end else if (rx_bit_en) begin
			line_hist_r <= {line_hist_r[3:0], rx_line_bit};
			up_ok_r <= (rx_line_bit == line_hist_r[4]) &&
				$onehot(line_hist_r);
			down_ok_r <= (rx_line_bit == line_hist_r[2]) &&
				$onehot(line_hist_r[2:0]);
		end
	end

	// The count saturates so a held code raises the flag only once
	always_ff @(posedge sys_clk) begin
		if (rst)
			loop_cnt_r <= '0;
		else if (!(up_ok_r || down_ok_r))
			loop_cnt_r <= '0;
		else if (loop_cnt_r != LOOP_W'(LOOP_HOLD_CYC))
			loop_cnt_r <= loop_cnt_r + 1'b1;
	end

	assign loop_evt = (loop_cnt_r == LOOP_W'(LOOP_HOLD_CYC - 1)) &&
		(up_ok_r || down_ok_r);

	// Message and signaling sub-detectors

	logic msg_new;
	logic sig_change;

	tcof_bom_detect u_bom (
		.sys_clk(sys_clk),
		.rst(rst),
		.link_bit(facility_data_link),
		.link_bit_en(facility_data_link_en),
		.msg_new(msg_new)
	);

	tcof_sig_change u_sig (
		.sys_clk(sys_clk),
		.rst(rst),
		.sig_bits(sig_bits),
		.sig_en(sig_en),
		.debounce_en(signaling_debounce_enable),
		.sig_change(sig_change)
	);

	// Link and event interrupt word

	always_comb begin
		event_evt = 7'h00;
		event_evt[`TCOF_BIT_LINK_A] = data_link_ctrl_a_irq;
		event_evt[`TCOF_BIT_LINK_B] = data_link_ctrl_b_irq;
		event_evt[`TCOF_BIT_LOOP] = loop_evt;
		event_evt[`TCOF_BIT_ONE_SEC] = one_sec_rise;
		event_evt[`TCOF_BIT_FIVE_SEC] = five_sec_rise;
		event_evt[`TCOF_BIT_MESSAGE] = msg_new;
		event_evt[`TCOF_BIT_SIGNALING] = sig_change;
	end

	// Bit 7 is unused and reads as zero
	always_ff @(posedge sys_clk) begin
		if (rst)
			event_irq_r <= `TCOF_RESET_WORD;
		else
			event_irq_r <= (rd_event ? `TCOF_RESET_WORD : event_irq_r) |
				{1'b0, event_evt & event_unmask};
	end

	// Processor read port
	// Data shows the word as it stood before the clearing edge.

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cpu_rdata <= `TCOF_RESET_WORD;
			cpu_rdata_valid <= 1'b0;
		end else begin
			cpu_rdata_valid <= cpu_rd;
			if (rd_wrap)
				cpu_rdata <= wrap_irq_r;
			else if (rd_event)
				cpu_rdata <= event_irq_r;
			else if (rd_latch)
				cpu_rdata <= wrap_latch_r;
			else
				cpu_rdata <= `TCOF_RESET_WORD;
		end
	end

	// Checks

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	generate
		for (gi = 0; gi < 8; gi++) begin : g_chk
			a_wrap_irq_set: assert property (
				is_wrap(prev_cnt_r[gi], perf_cnt[gi]) && wrap_unmask[gi]
				|=> wrap_irq_r[gi])
				else $error("unmasked counter wrap did not set its bit");
			a_wrap_masked: assert property (
				!wrap_irq_r[gi] && !(wrap_evt[gi] && wrap_unmask[gi])
				|=> !wrap_irq_r[gi])
				else $error("interrupt bit rose without unmasked wrap");
			a_latch_set: assert property (
				wrap_evt[gi] |=> wrap_latch_r[gi])
				else $error("overflow latch missed a wrap");
			a_wrap_holds: assert property (
				wrap_irq_r[gi] && !rd_wrap |=> wrap_irq_r[gi])
				else $error("word two bit dropped without a read");
		end
	endgenerate

	a_read_clears: assert property (
		rd_wrap && !(|(wrap_evt & wrap_unmask)) |=>
		wrap_irq_r == 8'h00 && cpu_rdata == $past(wrap_irq_r))
		else $error("read did not return and clear word two");

	a_latch_clears: assert property (
		rd_latch && !(|wrap_evt) |=>
		wrap_latch_r == 8'h00 && cpu_rdata == $past(wrap_latch_r))
		else $error("read did not return and clear the latch");

	a_event_clears: assert property (
		rd_event && !(|(event_evt & event_unmask)) |=>
		event_irq_r == 8'h00 && cpu_rdata == $past(event_irq_r))
		else $error("read did not return and clear word three");

	a_set_wins_clear: assert property (
		rd_event && event_evt[`TCOF_BIT_LINK_A] &&
		event_unmask[`TCOF_BIT_LINK_A] |=> event_irq_r[`TCOF_BIT_LINK_A])
		else $error("event lost in clearing read cycle");

	a_link_b_irq: assert property (
		data_link_ctrl_b_irq && event_unmask[`TCOF_BIT_LINK_B]
		|=> event_irq_r[`TCOF_BIT_LINK_B])
		else $error("controller B event not flagged");

	a_link_a_irq: assert property (
		data_link_ctrl_a_irq && event_unmask[`TCOF_BIT_LINK_A]
		|=> event_irq_r[`TCOF_BIT_LINK_A])
		else $error("controller A event not flagged");

	// The match must already have stood in the cycle before the flag
	a_loop_hold: assert property (
		loop_evt |-> $past(up_ok_r || down_ok_r))
		else $error("loop code flagged before hold time");

	a_loop_once: assert property (
		loop_evt |=> !loop_evt)
		else $error("loop code flagged twice in a row");

	a_loop_irq: assert property (
		loop_evt && event_unmask[`TCOF_BIT_LOOP]
		|=> event_irq_r[`TCOF_BIT_LOOP])
		else $error("loop code event not flagged");

	a_one_sec_rise: assert property (
		$rose(one_second_flag) && event_unmask[`TCOF_BIT_ONE_SEC]
		|=> event_irq_r[`TCOF_BIT_ONE_SEC])
		else $error("one-second rise not flagged");

	a_five_sec_rise: assert property (
		!five_second_flag ##1 five_second_flag &&
		event_unmask[`TCOF_BIT_FIVE_SEC] |=> event_irq_r[`TCOF_BIT_FIVE_SEC])
		else $error("five-second rise not flagged");

	a_bom_irq: assert property (
		msg_new && event_unmask[`TCOF_BIT_MESSAGE]
		|=> event_irq_r[`TCOF_BIT_MESSAGE])
		else $error("new message not flagged");

	a_sig_irq: assert property (
		sig_change && event_unmask[`TCOF_BIT_SIGNALING]
		|=> event_irq_r[`TCOF_BIT_SIGNALING])
		else $error("signaling change not flagged");

	a_unused_bit: assert property (event_irq_r[7] == 1'b0)
		else $error("unused bit of word three set");

	generate
		for (gi = 0; gi < 7; gi++) begin : g_evt_chk
			a_event_masked: assert property (
				!event_irq_r[gi] && !(event_evt[gi] && event_unmask[gi])
				|=> !event_irq_r[gi])
				else $error("word three bit rose without unmasked event");
			a_event_holds: assert property (
				event_irq_r[gi] && !rd_event |=> event_irq_r[gi])
				else $error("word three bit dropped without a read");
		end
	endgenerate

	a_read_answer: assert property (cpu_rd |=> cpu_rdata_valid)
		else $error("read not answered in the next cycle");

	a_idle_quiet: assert property (
		!cpu_rd |=> !cpu_rdata_valid && cpu_rdata == 8'h00)
		else $error("read port active without a read");

	a_unmapped_zero: assert property (
		cpu_rd && !(rd_wrap || rd_event || rd_latch) |=> cpu_rdata == 8'h00)
		else $error("unmapped read returned data");

	c_wrap_read: cover property (wrap_evt[7] ##[1:20] rd_wrap);
	c_loop_seen: cover property (loop_evt);
	c_msg_seen: cover property (msg_new);
	c_sig_seen: cover property (sig_change && signaling_debounce_enable);
endmodule : tcof_event_flags

// [testbench/tcof_event_flags_tb.sv]
// Self-checking bench for the T1 counter overflow event flags.
// Assumes the design files and tcof_pkg are compiled first; the loop-code
// hold is shortened so that the whole run stays brief.
`timescale 1ns/1ps

module tcof_event_flags_tb import tcof_pkg::*;;

	localparam int HOLD = 50;
	localparam logic [13:0] BOM_WORD = 14'b11111110_10110_0;

	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cpu_rd = 1'b0;
	logic [4:0] cpu_addr = 5'h00;
	logic [7:0] cpu_rdata;
	logic cpu_rdata_valid;
	logic [7:0][7:0] perf_cnt = '0;
	logic [7:0] wrap_unmask = 8'hff;
	logic [6:0] event_unmask = 7'h7f;
	logic data_link_ctrl_a_irq = 1'b0;
	logic data_link_ctrl_b_irq = 1'b0;
	logic rx_line_bit = 1'b0;
	logic rx_bit_en = 1'b0;
	logic one_second_flag = 1'b0;
	logic five_second_flag = 1'b0;
	logic facility_data_link = 1'b0;
	logic facility_data_link_en = 1'b0;
	logic [3:0] sig_bits = 4'h0;
	logic sig_en = 1'b0;
	logic signaling_debounce_enable = 1'b0;
	int n_errors = 0;
	int cmp_count = 0;

	tcof_event_flags #(.LOOP_HOLD_CYC(HOLD)) u_tcof_event_flags (
		.sys_clk(sys_clk),
		.rst(rst),
		.cpu_rd(cpu_rd),
		.cpu_addr(cpu_addr),
		.cpu_rdata(cpu_rdata),
		.cpu_rdata_valid(cpu_rdata_valid),
		.perf_cnt(perf_cnt),
		.wrap_unmask(wrap_unmask),
		.event_unmask(event_unmask),
		.data_link_ctrl_a_irq(data_link_ctrl_a_irq),
		.data_link_ctrl_b_irq(data_link_ctrl_b_irq),
		.rx_line_bit(rx_line_bit),
		.rx_bit_en(rx_bit_en),
		.one_second_flag(one_second_flag),
		.five_second_flag(five_second_flag),
		.facility_data_link(facility_data_link),
		.facility_data_link_en(facility_data_link_en),
		.sig_bits(sig_bits),
		.sig_en(sig_en),
		.signaling_debounce_enable(signaling_debounce_enable)
	);

	always #4 sys_clk = ~sys_clk;

	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string what, input tcof_word_type exp,
			input tcof_word_type got);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc

	// Read is taken at the next rising edge; the answer stands one cycle
	task automatic rd(input logic [4:0] addr, input tcof_word_type exp);
		cpu_rd = 1'b1;
		cpu_addr = addr;
		cyc(1);
		chk("rdata_valid", 8'h01, {7'h00, cpu_rdata_valid});
		chk($sformatf("word %h", addr), exp, cpu_rdata);
		cpu_rd = 1'b0;
		cyc(1);
	endtask : rd

	task automatic t_reset_and_unmapped;
		rd(5'h1d, 8'h00);
		rd(5'h1e, 8'h00);
		rd(5'h1f, 8'h00);
		rd(5'h03, 8'h00);
	endtask : t_reset_and_unmapped

	// Each counter wraps alone; a near miss ff->01 must not count
	task automatic t_wraps(input logic [7:0] mask);
		wrap_unmask = mask;
		for (int i = 0; i < 8; i++) begin
			perf_cnt[i] = 8'hff;
			cyc(1);
			perf_cnt[i] = 8'h01;
			cyc(1);
			perf_cnt[i] = 8'hff;
			cyc(1);
			perf_cnt[i] = 8'h00;
			cyc(2);
			rd(5'h1d, mask & (8'h01 << i));
			rd(5'h1d, 8'h00);
			rd(5'h1f, 8'h01 << i);
			rd(5'h1f, 8'h00);
		end
	endtask : t_wraps

	task automatic t_event_sources(input logic [6:0] mask);
		event_unmask = mask;
		data_link_ctrl_a_irq = 1'b1;
		data_link_ctrl_b_irq = 1'b1;
		one_second_flag = 1'b1;
		five_second_flag = 1'b1;
		cyc(1);
		data_link_ctrl_a_irq = 1'b0;
		data_link_ctrl_b_irq = 1'b0;
		cyc(2);
		// An unmapped read must leave the pending flags alone
		rd(5'h03, 8'h00);
		rd(5'h1e, {1'b0, mask} & 8'h6c);
		cyc(3);
		rd(5'h1e, 8'h00);
		one_second_flag = 1'b0;
		five_second_flag = 1'b0;
		event_unmask = 7'h7f;
		cyc(1);
	endtask : t_event_sources

	// Event lands in the very cycle the read clears the word
	task automatic t_set_beats_clear;
		data_link_ctrl_b_irq = 1'b1;
		cyc(1);
		data_link_ctrl_b_irq = 1'b0;
		cpu_rd = 1'b1;
		cpu_addr = 5'h1e;
		data_link_ctrl_a_irq = 1'b1;
		cyc(1);
		chk("rdata_valid", 8'h01, {7'h00, cpu_rdata_valid});
		chk("word 1e on racing read", 8'h20, cpu_rdata);
		cpu_rd = 1'b0;
		data_link_ctrl_a_irq = 1'b0;
		cyc(1);
		rd(5'h1e, 8'h40);
	endtask : t_set_beats_clear

	task automatic sig_sample(input logic [3:0] v);
		sig_bits = v;
		sig_en = 1'b1;
		cyc(1);
		sig_en = 1'b0;
		cyc(2);
	endtask : sig_sample

	task automatic t_signaling;
		signaling_debounce_enable = 1'b0;
		sig_sample(4'h0);
		rd(5'h1e, 8'h00);
		sig_sample(4'h5);
		rd(5'h1e, 8'h01);
		signaling_debounce_enable = 1'b1;
		sig_sample(4'ha);
		sig_sample(4'h5);
		rd(5'h1e, 8'h00);
		sig_sample(4'ha);
		sig_sample(4'ha);
		rd(5'h1e, 8'h01);
	endtask : t_signaling

	// Zeros first, so a code still held from before starts a fresh count
	task automatic t_loop_code(input int period);
		rx_line_bit = 1'b0;
		rx_bit_en = 1'b1;
		cyc(6);
		rd(5'h1e, 8'h00);
		for (int k = 0; k < HOLD + 6 * period; k++) begin
			rx_line_bit = (k % period == period - 1);
			cyc(1);
		end
		rx_bit_en = 1'b0;
		rx_line_bit = 1'b0;
		rd(5'h1e, 8'h10);
	endtask : t_loop_code

	task automatic send_bom(input int reps);
		for (int r = 0; r < reps; r++) begin
			for (int k = 13; k >= 0; k--) begin
				facility_data_link = BOM_WORD[k];
				facility_data_link_en = 1'b1;
				cyc(1);
				facility_data_link_en = 1'b0;
				cyc(1);
			end
		end
		cyc(2);
	endtask : send_bom

	// Seven sightings are one short of acceptance, the eighth accepts
	task automatic t_bit_message;
		send_bom(7);
		rd(5'h1e, 8'h00);
		send_bom(1);
		rd(5'h1e, 8'h02);
		send_bom(3);
		rd(5'h1e, 8'h00);
	endtask : t_bit_message

	initial begin
		cyc(20);
		rst = 1'b0;
		t_reset_and_unmapped();
		t_wraps(8'hff);
		t_wraps(8'h5a);
		t_event_sources(7'h7f);
		t_event_sources(7'h24);
		t_set_beats_clear();
		t_signaling();
		t_loop_code(5);
		t_loop_code(3);
		t_bit_message();
		tally_and_finish();
	end

	// Whole sequence needs well under 3000 cycles
	initial begin
		#(8 * 20000);
		n_errors++;
		tally_and_finish();
	end

endmodule : tcof_event_flags_tb
